// *** core/bt_decode_pkg.sv ***
// constants and types for the branch, trap and cache-op decoder
// Summary of operation
// - branch target: offset shifted left two, sign-extended, added to slot address
// - negative likely branch taken when sign bit set: bit 31 or 63
// - taken branch redirects the pc after the one delay-slot instruction
// - likely branches nullify the delay slot when the condition is false
// - unequal branches compare whole registers in 64-bit mode, low words in 32-bit mode; taken only when they differ
// - trap instruction raises a breakpoint exception at once, always
// - the 20-bit trap parameter field is ignored by hardware
// - cache op address is sign-extended offset plus base, then translated
// - the 5-bit sub-operation field chooses the maintenance operation
// - user/supervisor with coprocessor 0 disabled takes coprocessor unusable
// - unlisted combinations, other caches and uncached addresses are undefined
// - index ops pick the block from bits between size exponents, no tag match
// - index tag read picks the parity doubleword from block bits down to 3
// - fill with parity override writes parity from the parity error register
// - hit ops look up like data references and act only on a hit
// - write-back goes to the address held in the cache tag
// - cache ops may raise tlb refill or invalid, never tlb modified
// - bits 17:16 select cache: 0 instruction, 1 data, 2-3 undefined
// - bits 20:18 encode the operation on the selected cache
package bt_decode_pkg;
    localparam logic [5:0] op_reg_immediate_group = 6'h01;
    localparam logic [5:0] op_function_group = 6'h00;
    localparam logic [5:0] op_branch_unequal = 6'h05;
    localparam logic [5:0] op_branch_unequal_likely = 6'h15;
    localparam logic [5:0] op_cache = 6'h2f;
    localparam logic [4:0] rt_branch_negative_likely = 5'h02;
    localparam logic [5:0] fn_breakpoint = 6'h0d;
    localparam int opcode_hi = 31;
    localparam int opcode_lo = 26;
    localparam int rt_hi = 20;
    localparam int rt_lo = 16;
    localparam int fn_hi = 5;
    localparam int cache_sel_hi = 17;
    localparam int cache_sel_lo = 16;
    localparam int cache_op_hi = 20;
    localparam int cache_op_lo = 18;
    localparam int store_size_log2 = 12;
    localparam int block_size_log2 = 4;
    localparam int dword_lo = 3;
    localparam int index_w = store_size_log2 - block_size_log2;
    localparam int dword_w = block_size_log2 - dword_lo;
    localparam logic [1:0] cache_instr = 2'h0;
    localparam logic [1:0] cache_data = 2'h1;
    localparam logic [2:0] cop_index_inval = 3'h0;
    localparam logic [2:0] cop_index_load_tag = 3'h1;
    localparam logic [2:0] cop_index_store_tag = 3'h2;
    localparam logic [2:0] cop_create_dirty = 3'h3;
    localparam logic [2:0] cop_hit_inval = 3'h4;
    localparam logic [2:0] cop_hit_wb_inval = 3'h5;
    localparam logic [2:0] cop_hit_wb = 3'h6;
    localparam logic [1:0] mode_kernel = 2'h0;
    typedef enum logic [3:0] {
        act_none = 4'h0,
        act_index_inval = 4'h1,
        act_index_wb_inval = 4'h2,
        act_index_load_tag = 4'h3,
        act_index_store_tag = 4'h4,
        act_create_dirty = 4'h5,
        act_hit_inval = 4'h6,
        act_hit_wb_inval = 4'h7,
        act_fill = 4'h8,
        act_hit_wb = 4'h9,
        act_undefined = 4'hf
    } cache_act_t;
    typedef enum logic [0:0] {
        slot_idle = 1'b0,
        slot_pending = 1'b1
    } slot_state_t;
endpackage

// *** core/branch_trap_cacheop_decode.sv ***
// decoder for likely/unequal branches, breakpoint trap and cache maintenance
`timescale 1ns/1ps
module branch_trap_cacheop_decode
    import bt_decode_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // issued instruction
    input wire logic instr_valid,
    input wire logic [31:0] instr_word,
    input wire logic [63:0] instr_pc,
    input wire logic [63:0] src_a,
    input wire logic [63:0] src_b,
    // processor state
    input wire logic mode_64,
    input wire logic [1:0] priv_mode,
    input wire logic cop0_enable,
    input wire logic parity_override,
    input wire logic [7:0] parity_error_reg,
    // translation result
    input wire logic tlb_refill,
    input wire logic tlb_invalid,
    input wire logic tlb_modified,
    // branch control
    output logic redirect_valid,
    output logic [63:0] redirect_pc,
    output logic nullify_slot,
    // exceptions
    output logic break_exc,
    output logic cop_unusable_exc,
    output logic tlb_refill_exc,
    output logic tlb_invalid_exc,
    // cache operation
    output logic cache_op_valid,
    output cache_act_t cache_act,
    output logic [1:0] cache_sel,
    output logic [63:0] cache_vaddr,
    output logic [index_w-1:0] cache_index,
    output logic [dword_w-1:0] cache_dword,
    output logic cache_need_tag_match,
    output logic cache_wb_from_tag,
    output logic cache_parity_force,
    output logic [7:0] cache_parity_val
);

    // ignores the breakpoint code field entirely
    function automatic logic is_break(input logic [31:0] w);
        return w[opcode_hi:opcode_lo] == op_function_group &&
            w[fn_hi:0] == fn_breakpoint;
    endfunction

    function automatic cache_act_t decode_cop(input logic [1:0] sel,
        input logic [2:0] code);
        cache_act_t a;
        a = act_undefined;
        if (sel == cache_instr)
        begin
            unique case (code)
                cop_index_inval: a = act_index_inval;
                cop_index_load_tag: a = act_index_load_tag;
                cop_index_store_tag: a = act_index_store_tag;
                cop_hit_inval: a = act_hit_inval;
                cop_hit_wb_inval: a = act_fill;
                cop_hit_wb: a = act_hit_wb;
                default: a = act_undefined;
            endcase
        end
        else if (sel == cache_data)
        begin
            unique case (code)
                cop_index_inval: a = act_index_wb_inval;
                cop_index_load_tag: a = act_index_load_tag;
                cop_index_store_tag: a = act_index_store_tag;
                cop_create_dirty: a = act_create_dirty;
                cop_hit_inval: a = act_hit_inval;
                cop_hit_wb_inval: a = act_hit_wb_inval;
                cop_hit_wb: a = act_hit_wb;
                default: a = act_undefined;
            endcase
        end
        return a;
    endfunction

    logic [5:0] opcode;
    logic is_neg_likely;
    logic is_une;
    logic is_une_likely;
    logic is_branch;
    logic is_cache;
    logic cond;
    logic [63:0] a_w;
    logic [63:0] b_w;
    logic [63:0] off_ext;
    logic [63:0] slot_pc;
    logic [63:0] target;
    logic [63:0] cvaddr;
    logic cop_ok;
    cache_act_t act_dec;
    logic cache_go;
    cache_act_t act_issue;
    slot_state_t slot_reg;
    slot_state_t slot_next;
    logic [63:0] target_reg;
    logic taken_reg;
    logic likely_reg;

    assign opcode = instr_word[opcode_hi:opcode_lo];
    assign is_neg_likely = opcode == op_reg_immediate_group &&
        instr_word[rt_hi:rt_lo] == rt_branch_negative_likely;
    assign is_une = opcode == op_branch_unequal;
    assign is_une_likely = opcode == op_branch_unequal_likely;
    assign is_branch = instr_valid &&
        (is_neg_likely || is_une || is_une_likely);
    assign is_cache = instr_valid && opcode == op_cache;

    // 32-bit mode looks only at the low word
    assign a_w = mode_64 ? src_a : {32'h0, src_a[31:0]};
    assign b_w = mode_64 ? src_b : {32'h0, src_b[31:0]};

    always_comb
    begin
        if (is_neg_likely)
            cond = mode_64 ? src_a[63] : src_a[31];
        else
            cond = a_w != b_w;
    end

    assign off_ext = {{46{instr_word[15]}}, instr_word[15:0], 2'h0};
    assign slot_pc = instr_pc + 64'h4;
    always_comb
    begin
        target = slot_pc + off_ext;
        if (!mode_64)
            target = {{32{target[31]}}, target[31:0]};
    end

    assign cvaddr = src_a + {{48{instr_word[15]}}, instr_word[15:0]};
    assign cop_ok = priv_mode == mode_kernel || cop0_enable;
    assign act_dec = decode_cop(instr_word[cache_sel_hi:cache_sel_lo],
        instr_word[cache_op_hi:cache_op_lo]);
    // refused or faulting cache ops show no action at all
    assign cache_go = is_cache && cop_ok && !tlb_refill && !tlb_invalid;
    assign act_issue = cache_go ? act_dec : act_none;

    // remember the branch until the slot instruction issues
    always_comb
    begin
        slot_next = slot_reg;
        unique case (slot_reg)
            slot_idle:
                if (is_branch)
                    slot_next = slot_pending;
            slot_pending:
                if (instr_valid)
                    slot_next = slot_idle;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            slot_reg <= slot_idle;
        else
            slot_reg <= slot_next;
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            target_reg <= 64'h0;
            taken_reg <= 1'b0;
            likely_reg <= 1'b0;
        end
        else if (slot_reg == slot_idle && is_branch)
        begin
            target_reg <= target;
            taken_reg <= cond;
            likely_reg <= is_neg_likely || is_une_likely;
        end
    end

    // redirect and nullify issue with the slot instruction
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            redirect_valid <= 1'b0;
            redirect_pc <= 64'h0;
            nullify_slot <= 1'b0;
        end
        else
        begin
            redirect_valid <= slot_reg == slot_pending && instr_valid &&
                taken_reg;
            redirect_pc <= target_reg;
            // plain unequal never nullifies
            nullify_slot <= slot_reg == slot_pending && instr_valid &&
                likely_reg && !taken_reg;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            break_exc <= 1'b0;
            cop_unusable_exc <= 1'b0;
            tlb_refill_exc <= 1'b0;
            tlb_invalid_exc <= 1'b0;
        end
        else
        begin
            break_exc <= instr_valid && is_break(instr_word);
            cop_unusable_exc <= is_cache && !cop_ok;
            // tlb_modified is deliberately dropped for cache ops
            tlb_refill_exc <= is_cache && cop_ok && tlb_refill;
            tlb_invalid_exc <= is_cache && cop_ok &&
                tlb_invalid && !tlb_refill;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            cache_op_valid <= 1'b0;
            cache_act <= act_none;
            cache_sel <= 2'h0;
            cache_vaddr <= 64'h0;
            cache_index <= '0;
            cache_dword <= '0;
            cache_need_tag_match <= 1'b0;
            cache_wb_from_tag <= 1'b0;
            cache_parity_force <= 1'b0;
            cache_parity_val <= 8'h0;
        end
        else
        begin
            cache_op_valid <= cache_go;
            cache_act <= act_issue;
            cache_sel <= instr_word[cache_sel_hi:cache_sel_lo];
            cache_vaddr <= cvaddr;
            cache_index <=
                cvaddr[store_size_log2-1:block_size_log2];
            cache_dword <=
                cvaddr[block_size_log2-1:dword_lo];
            // hit ops compare tags; index ops do not
            cache_need_tag_match <= act_issue == act_hit_inval ||
                act_issue == act_hit_wb_inval || act_issue == act_hit_wb ||
                act_issue == act_fill;
            cache_wb_from_tag <= act_issue == act_index_wb_inval ||
                act_issue == act_create_dirty || act_issue == act_hit_wb ||
                act_issue == act_hit_wb_inval;
            cache_parity_force <= act_issue == act_fill &&
                parity_override;
            cache_parity_val <= parity_error_reg;
        end
    end

    redirect_after_slot_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        redirect_valid |-> $past(slot_reg) == slot_pending &&
            $past(instr_valid))
        else $error("redirect without a delay slot");

    unequal_no_nullify_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (slot_reg == slot_idle && is_branch && is_une) ##1
            (instr_valid [*1]) |=> !nullify_slot)
        else $error("plain unequal nullified slot");

    likely_false_null_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (slot_reg == slot_idle && is_branch && is_neg_likely && !cond)
            ##1 instr_valid |=> nullify_slot && !redirect_valid)
        else $error("false likely branch not nullified");

    neg_sign_taken_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (slot_reg == slot_idle && is_branch && is_neg_likely &&
            mode_64 && src_a[63]) ##1 instr_valid |=> redirect_valid)
        else $error("negative branch not taken");

    unequal_compare_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (slot_reg == slot_idle && is_branch && (is_une || is_une_likely) &&
            mode_64 && src_a != src_b) ##1 instr_valid |=> redirect_valid)
        else $error("unequal registers did not branch");

    target_formed_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        slot_reg == slot_idle && is_branch && mode_64 |=>
            target_reg == $past(instr_pc) + 64'h4 +
            {{46{$past(instr_word[15])}}, $past(instr_word[15:0]), 2'h0})
        else $error("branch target wrong");

    narrow_target_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        slot_reg == slot_idle && is_branch && !mode_64 |=>
            target_reg[63:32] == {32{target_reg[31]}})
        else $error("32-bit target not sign-extended");

    break_at_once_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        instr_valid && is_break(instr_word) |=> break_exc)
        else $error("breakpoint not raised");

    cop_unusable_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        is_cache && priv_mode != mode_kernel && !cop0_enable |=>
            cop_unusable_exc && !cache_op_valid)
        else $error("cop unusable missed");

    tlb_refill_taken_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        is_cache && cop_ok && tlb_refill |=> tlb_refill_exc &&
            !tlb_invalid_exc && !cache_op_valid)
        else $error("tlb refill not raised");

    modified_ignored_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        is_cache && cop_ok && tlb_modified && !tlb_refill &&
            !tlb_invalid |=> cache_op_valid && !tlb_refill_exc &&
            !tlb_invalid_exc)
        else $error("tlb modified blocked a cache op");

    cache_address_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        is_cache |=> cache_vaddr == $past(src_a) +
            {{48{$past(instr_word[15])}}, $past(instr_word[15:0])})
        else $error("cache address wrong");

    index_block_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        cache_op_valid |->
            cache_index == cache_vaddr[store_size_log2-1:block_size_log2] &&
            cache_dword == cache_vaddr[block_size_log2-1:dword_lo])
        else $error("cache index bits wrong");

    undefined_cache_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        cache_op_valid && cache_sel[1] |-> cache_act == act_undefined)
        else $error("undefined cache decoded as real op");

    parity_force_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        cache_parity_force |-> cache_act == act_fill &&
            $past(parity_override))
        else $error("parity forced wrongly");

    parity_value_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        cache_parity_force |-> cache_parity_val == $past(parity_error_reg))
        else $error("parity value not from error register");

endmodule

// *** test/tlb_model.sv ***
// translation model answering the cache-op address in the issue cycle
`timescale 1ns/1ps
module tlb_model
    import bt_decode_pkg::*;
(
    // issued instruction
    input wire logic instr_valid,
    input wire logic [31:0] instr_word,
    input wire logic [63:0] src_a,
    // translation result
    output logic tlb_refill,
    output logic tlb_invalid,
    output logic tlb_modified
);
    logic is_cache;
    logic [63:0] vaddr;
    assign is_cache = instr_valid && instr_word[31:26] == op_cache;
    assign vaddr = src_a + {{48{instr_word[15]}}, instr_word[15:0]};
    // region a misses, region b invalid, region 8 unmapped never faults
    assign tlb_refill = is_cache && vaddr[63:60] == 4'ha;
    assign tlb_invalid = is_cache && vaddr[63:60] == 4'hb;
    // high for every cache op: a modified fault must never reach the core outputs
    assign tlb_modified = is_cache;
endmodule

// *** test/testbench.sv ***
// self-checking bench for the branch, trap and cache-op decoder
`timescale 1ns/1ps
module testbench;
    import bt_decode_pkg::*;
    typedef struct packed {
        logic [31:0] word;
        logic [63:0] base;
        logic [2:0] st;
        logic [7:0] flags;
        logic [7:0] mask;
        cache_act_t act;
    } row_t;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic instr_valid = 1'b0;
    logic [31:0] instr_word = 32'h0;
    logic [63:0] instr_pc = 64'h0;
    logic [63:0] src_a = 64'h0;
    logic [63:0] src_b = 64'h0;
    logic mode_64 = 1'b1;
    logic [1:0] priv_mode = 2'h0;
    logic cop0_enable = 1'b0;
    logic parity_override = 1'b0;
    logic [7:0] parity_error_reg = 8'h5a;
    logic tlb_refill, tlb_invalid, tlb_modified;
    logic redirect_valid, nullify_slot, break_exc, cop_unusable_exc;
    logic tlb_refill_exc, tlb_invalid_exc, cache_op_valid;
    logic cache_need_tag_match, cache_wb_from_tag, cache_parity_force;
    logic [63:0] redirect_pc, cache_vaddr, ev;
    cache_act_t cache_act;
    logic [1:0] cache_sel;
    logic [index_w-1:0] cache_index;
    logic [dword_w-1:0] cache_dword;
    logic [7:0] cache_parity_val, seen_flags, fl, ef;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    row_t rows [18];
    assign seen_flags = {break_exc, cop_unusable_exc, tlb_refill_exc,
        tlb_invalid_exc, cache_op_valid, cache_need_tag_match,
        cache_wb_from_tag, cache_parity_force};
    always #12.5 core_clk = ~core_clk;
    branch_trap_cacheop_decode u_branch_trap_cacheop_decode (.*);
    tlb_model u_tlb_model (.instr_valid(instr_valid),
        .instr_word(instr_word), .src_a(src_a), .tlb_refill(tlb_refill),
        .tlb_invalid(tlb_invalid), .tlb_modified(tlb_modified));
    task automatic end_of_test();
        $display("compared %0d, mismatched %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] cw(input int c, s,
        input logic [15:0] off);
        return {op_cache, 5'h03, c[2:0], s[1:0], off};
    endfunction
    // branch at c0, nop slot at c1, outcome seen in c2
    task automatic br(input logic [31:0] w, input logic [63:0] pc, a, b,
        input logic m, r, input logic [63:0] t, input logic n);
        mode_64 = m;
        instr_word = w;
        instr_pc = pc;
        src_a = a;
        src_b = b;
        instr_valid = 1'b1;
        @(negedge core_clk);
        check(redirect_valid, 1'b0);
        instr_word = 32'h0;
        instr_pc = pc + 64'h4;
        @(negedge core_clk);
        instr_valid = 1'b0;
        check(redirect_valid, r);
        if (r)
            check(redirect_pc, t);
        check(nullify_slot, n);
        @(negedge core_clk);
        check(redirect_valid, 1'b0);
    endtask
    // ceiling well above the roughly 60 cycles the tests need
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            mismatches++;
            end_of_test();
        end
    end
    initial
    begin
        rows[0] = '{{op_function_group, 20'habcde, fn_breakpoint}, 64'h0,
            3'h0, 8'h80, 8'hff, act_none};
        rows[1] = '{cw(0, 0, 16'hfff8), 64'h8000_0000_0000_1000, 3'h0,
            8'h08, 8'hff, act_index_inval};
        rows[2] = '{cw(0, 1, 16'h0010), 64'h1000, 3'h0, 8'h0a, 8'hff,
            act_index_wb_inval};
        rows[3] = '{cw(1, 1, 16'h0018), 64'h1000, 3'h0, 8'h08, 8'hff,
            act_index_load_tag};
        rows[4] = '{cw(2, 0, 16'h0004), 64'h1000, 3'h0, 8'h08, 8'hff,
            act_index_store_tag};
        rows[5] = '{cw(3, 1, 16'h0020), 64'h1000, 3'h0, 8'h0a, 8'hff,
            act_create_dirty};
        rows[6] = '{cw(4, 1, 16'h0028), 64'h1000, 3'h0, 8'h0c, 8'hff,
            act_hit_inval};
        rows[7] = '{cw(5, 1, 16'h0030), 64'h1000, 3'h0, 8'h0e, 8'hff,
            act_hit_wb_inval};
        rows[8] = '{cw(5, 0, 16'h0038), 64'h1000, 3'h1, 8'h0d, 8'hff,
            act_fill};
        rows[9] = '{cw(6, 1, 16'h0040), 64'h1000, 3'h0, 8'h0e, 8'hff,
            act_hit_wb};
        rows[10] = '{cw(6, 0, 16'h0048), 64'h1000, 3'h0, 8'h0e, 8'hff,
            act_hit_wb};
        rows[11] = '{cw(0, 2, 16'h0), 64'h1000, 3'h0, 8'h0, 8'h0,
            act_undefined};
        rows[12] = '{cw(7, 1, 16'h0), 64'h1000, 3'h0, 8'h0, 8'h0,
            act_undefined};
        rows[13] = '{cw(4, 1, 16'h0), 64'h1000, 3'h4, 8'h40, 8'hff,
            act_none};
        rows[14] = '{cw(4, 1, 16'h0), 64'h1000, 3'h6, 8'h0c, 8'hff,
            act_hit_inval};
        rows[15] = '{cw(0, 1, 16'h0), 64'ha000_0000_0000_1000, 3'h0,
            8'h20, 8'hff, act_none};
        rows[16] = '{cw(4, 1, 16'h0), 64'hb000_0000_0000_1000, 3'h0,
            8'h10, 8'hff, act_none};
        rows[17] = '{cw(5, 0, 16'h0008), 64'h1000, 3'h0, 8'h0c, 8'hff,
            act_fill};
        repeat (12) @(negedge core_clk);
        reset_n = 1'b1;
        check({seen_flags, redirect_valid, nullify_slot}, 10'h0);
        check(cache_act, act_none);
        $display("reset values done");
        // rows issue back to back, one per cycle
        for (int i = 0; i < 18; i++)
        begin
            instr_word = rows[i].word;
            src_a = rows[i].base;
            priv_mode = rows[i].st[2] ? 2'h3 : mode_kernel;
            cop0_enable = rows[i].st[1];
            parity_override = rows[i].st[0];
            instr_valid = 1'b1;
            @(negedge core_clk);
            ev = rows[i].base + {{48{rows[i].word[15]}}, rows[i].word[15:0]};
            fl = seen_flags & rows[i].mask;
            ef = rows[i].flags & rows[i].mask;
            check(fl, ef);
            check(fl[2:0], ef[2:0]);
            check(cache_act, rows[i].act);
            if (rows[i].flags[3] && rows[i].mask[3])
            begin
                check(cache_vaddr, ev);
                check({cache_sel, cache_index, cache_dword},
                    {rows[i].word[17:16], ev[11:3]});
            end
            if (rows[i].flags[0])
                check(cache_parity_val, 8'h5a);
        end
        instr_valid = 1'b0;
        cop0_enable = 1'b0;
        priv_mode = mode_kernel;
        @(negedge core_clk);
        $display("table cases done");
        br({op_branch_unequal_likely, 10'h22, 16'h0010}, 64'h2000,
            64'h100_0000_0000, 64'h0, 1'b1, 1'b1, 64'h2044, 1'b0);
        br({op_branch_unequal_likely, 10'h22, 16'h0010}, 64'h2000,
            64'h5, 64'h5, 1'b1, 1'b0, 64'h0, 1'b1);
        br({op_branch_unequal, 10'h22, 16'h0010}, 64'h2000,
            64'h5, 64'h5, 1'b1, 1'b0, 64'h0, 1'b0);
        br({op_branch_unequal, 10'h22, 16'hfffe}, 64'h2000,
            64'h5, 64'h6, 1'b1, 1'b1, 64'h1ffc, 1'b0);
        br({op_reg_immediate_group, 5'h01, rt_branch_negative_likely,
            16'h0}, 64'h2000, 64'h8000_0000_0000_0000, 64'h0, 1'b1, 1'b1,
            64'h2004, 1'b0);
        br({op_reg_immediate_group, 5'h01, rt_branch_negative_likely,
            16'h0}, 64'h2000, 64'h8000_0000, 64'h0, 1'b1, 1'b0, 64'h0, 1'b1);
        br({op_reg_immediate_group, 5'h01, rt_branch_negative_likely,
            16'h0}, 64'h7fff_fffc, 64'h8000_0000, 64'h0, 1'b0, 1'b1,
            64'hffff_ffff_8000_0000, 1'b0);
        br({op_branch_unequal_likely, 10'h22, 16'h0010}, 64'h2000,
            64'h100_0000_0000, 64'h0, 1'b0, 1'b0, 64'h0, 1'b1);
        $display("branch cases done");
        // reset landing on the slot edge drops the pending redirect
        br({op_function_group, 20'h0, fn_breakpoint}, 64'h0, 64'h0, 64'h0,
            1'b1, 1'b0, 64'h0, 1'b0);
        instr_word = {op_branch_unequal_likely, 10'h22, 16'h0010};
        src_a = 64'h1;
        instr_valid = 1'b1;
        @(negedge core_clk);
        reset_n = 1'b0;
        @(negedge core_clk);
        reset_n = 1'b1;
        // a slot candidate right after release must not see the old branch
        instr_word = 32'h0;
        check({redirect_valid, nullify_slot, break_exc}, 3'h0);
        @(negedge core_clk);
        instr_valid = 1'b0;
        check({redirect_valid, nullify_slot}, 2'h0);
        $display("mid-run reset done");
        end_of_test();
    end
endmodule
